// [iper_arbiter.sv]
/*
 Two-level priority picker: among pending sources, a high-priority one wins,
 then the lowest source number. A high request may preempt a running low
 routine; nothing preempts a high routine.
 Assumes pending vector is already masked by enables.
*/
`timescale 1ns/100ps
module iper_arbiter #(
   parameter int N = iper_pkg::NUM_SOURCES
) (
   // Requests
   input wire logic [N-1:0] i_pending,
   input wire logic [N-1:0] i_prio_high,
   // Level of routine now running
   input wire logic i_in_low,
   input wire logic i_in_high,
   // Winner
   output iper_pkg::iper_grant_t o_grant
);

   initial begin
      if (N > 15) begin
         $error("source count exceeds code width");
      end
   end

   logic [N-1:0] hi_req;
   logic [N-1:0] lo_req;

   always_comb begin
      hi_req = i_pending & i_prio_high;
      lo_req = i_pending & ~i_prio_high;
      o_grant = '{valid: 1'b0, high: 1'b0, source: iper_pkg::SRC_NONE};
      for (int k = N - 1; k >= 0; k--) begin
         if (lo_req[k] && !i_in_low && !i_in_high) begin
            o_grant = '{valid: 1'b1, high: 1'b0, source: iper_pkg::SRC_W'(k)};
         end
      end
      for (int k = N - 1; k >= 0; k--) begin
         if (hi_req[k] && !i_in_high) begin
            o_grant = '{valid: 1'b1, high: 1'b1, source: iper_pkg::SRC_W'(k)};
         end
      end
   end

endmodule

// [iper_assertions.sv]
/*
 Checker for iper_regs: register, masking and grant relations.
 Assumes it is bound to iper_regs and sees only its ports.
*/
`timescale 1ns/100ps
module iper_assertions (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // Bus and core
   input iper_pkg::iper_sfr_req_t i_sfr,
   input wire logic [7:0] o_rdata,
   input wire logic i_global_irq_enable,
   input iper_pkg::iper_ext_flags_t i_ext_flags,
   // Outputs
   input iper_pkg::iper_grant_t o_grant,
   input wire logic [14:0] o_masked_pending,
   input wire logic [7:0] o_basic_priority,
   input wire logic [7:0] o_extended_enable_one,
   input wire logic [7:0] o_extended_priority_one
);
   default clocking dc @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   a_fixed_bit_one: assert property (o_basic_priority[7])
      else $error("fixed priority bit low");
   a_global_gate: assert property (!i_global_irq_enable |->
      o_masked_pending == 15'h0 && !o_grant.valid) else $error("request without global enable");
   a_lin_mask: assert property (o_masked_pending[14] == (i_global_irq_enable &&
      o_extended_enable_one[7] && i_ext_flags.lin_pending_flag)) else $error("lin mask wrong");
   a_timer3_mask: assert property (o_masked_pending[13] == (i_global_irq_enable &&
      o_extended_enable_one[6] && (i_ext_flags.timer_three_low_overflow ||
      i_ext_flags.timer_three_high_overflow))) else $error("timer three mask wrong");
   a_enable_write: assert property (i_ce && i_sfr.wr && !i_sfr.bit_op &&
      i_sfr.addr == 8'hE6 |=> o_extended_enable_one == $past(i_sfr.wdata))
      else $error("enable write lost");
   a_hidden_page: assert property (i_ce && i_sfr.wr && i_sfr.addr == 8'hF6 &&
      i_sfr.page != 8'h00 && i_sfr.page != 8'h0F |=> $stable(o_extended_priority_one))
      else $error("hidden priority written");
   a_bit_write: assert property (i_ce && i_sfr.wr && i_sfr.bit_op &&
      i_sfr.addr == 8'hB8 && i_sfr.bit_sel != 3'h7 |=>
      o_basic_priority[$past(i_sfr.bit_sel)] == $past(i_sfr.wdata[0]))
      else $error("bit write lost");
   a_high_first: assert property (o_grant.valid && !o_grant.high |->
      ({o_extended_priority_one, o_basic_priority[6:0]} & o_masked_pending) == 15'h0)
      else $error("low granted over high");
   a_read_enable: assert property (i_ce && i_sfr.rd && i_sfr.addr == 8'hE6 |=>
      o_rdata == $past(o_extended_enable_one)) else $error("enable read wrong");
   a_reset_clear: assert property ($rose(i_rst_n) |-> o_basic_priority == 8'h80 &&
      o_extended_enable_one == 8'h00 && o_extended_priority_one == 8'h00)
      else $error("reset values wrong");
endmodule

bind iper_regs iper_assertions u_iper_assertions (.i_clk, .i_rst_n, .i_ce, .i_sfr, .o_rdata,
   .i_global_irq_enable, .i_ext_flags, .o_grant, .o_masked_pending, .o_basic_priority,
   .o_extended_enable_one, .o_extended_priority_one);

// [iper_core_model.sv]
/*
 Core model: enters a routine when told to take a valid grant, unless a return is strobed in the same cycle.
 Assumes the bench strobes take and return on the falling edge.
*/
`timescale 1ns/100ps
module iper_core_model (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Grant and control
   input iper_pkg::iper_grant_t i_grant,
   input wire logic i_take,
   input wire logic i_ret,
   // Routine level
   output logic o_in_low,
   output logic o_in_high
);
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_in_low <= 1'b0;
         o_in_high <= 1'b0;
      end else if (i_ret) begin
         if (o_in_high)
            o_in_high <= 1'b0;
         else
            o_in_low <= 1'b0;
      end else if (i_take && i_grant.valid) begin
         if (i_grant.high)
            o_in_high <= 1'b1;
         else
            o_in_low <= 1'b1;
      end
   end
endmodule

// [iper_pkg.sv]
/*
 Package for the interrupt priority and extended enable register block:
 special-function addresses, page codes, bit positions, reset values,
 source numbering and the structs that carry bus accesses and requests.
 Assumes a byte-wide special-function bus with bit access and paging.
*/
package iper_pkg;

   // Special-function addresses
   localparam logic [7:0] ADDR_BASIC_PRIORITY = 8'hB8;
   localparam logic [7:0] ADDR_EXT_ENABLE_ONE = 8'hE6;
   localparam logic [7:0] ADDR_EXT_PRIORITY_ONE = 8'hF6;

   // Pages on which the extended priority register is visible
   localparam logic [7:0] PAGE_PRIO_A = 8'h00;
   localparam logic [7:0] PAGE_PRIO_B = 8'h0F;

   // Reset values; bit 7 of basic priority always reads one
   localparam logic [7:0] RST_BASIC_PRIORITY = 8'h80;
   localparam logic [7:0] RST_EXT_ENABLE_ONE = 8'h00;
   localparam logic [7:0] RST_EXT_PRIORITY_ONE = 8'h00;
   localparam logic [7:0] BASIC_PRIORITY_FIXED = 8'h80;
   localparam logic [7:0] BASIC_PRIORITY_WMASK = 8'h7F;

   // Basic priority fields
   localparam int BIT_SERIAL_PERIPH_PRIO = 6;
   localparam int BIT_TIMER_TWO_PRIO = 5;
   localparam int BIT_UART_PRIO = 4;
   localparam int BIT_TIMER_ONE_PRIO = 3;
   localparam int BIT_EXT_INT_ONE_PRIO = 2;
   localparam int BIT_TIMER_ZERO_PRIO = 1;
   localparam int BIT_EXT_INT_ZERO_PRIO = 0;

   // Extended enable / priority fields (same position in both registers)
   localparam int BIT_LIN = 7;
   localparam int BIT_TIMER_THREE = 6;
   localparam int BIT_COMPARATOR_ONE = 5;
   localparam int BIT_COMPARATOR_ZERO = 4;
   localparam int BIT_COUNTER_ARRAY = 3;
   localparam int BIT_ADC_DONE = 2;
   localparam int BIT_ADC_WINDOW = 1;
   localparam int BIT_SMBUS = 0;

   // Sources, numbered in fixed polling order (lowest number wins a tie)
   localparam int NUM_SOURCES = 15;
   localparam int SRC_W = 4;
   localparam logic [SRC_W-1:0] SRC_NONE = 4'hF;

   // One special-function access
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] page;
      logic wr;
      logic rd;
      logic bit_op;
      logic [2:0] bit_sel;
      logic [7:0] wdata;
   } iper_sfr_req_t;

   // Raw flags from peripherals, one bit per flag
   typedef struct packed {
      logic lin_pending_flag;
      logic timer_three_low_overflow;
      logic timer_three_high_overflow;
      logic comparator_one_rise_flag;
      logic comparator_one_fall_flag;
      logic comparator_zero_rise_flag;
      logic comparator_zero_fall_flag;
      logic counter_array_req;
      logic adc_done_flag;
      logic adc_window_flag;
      logic smbus_req;
   } iper_ext_flags_t;

   // Winning request presented to the core
   typedef struct packed {
      logic valid;
      logic high;
      logic [SRC_W-1:0] source;
   } iper_grant_t;

endpackage

// [iper_regs.sv]
/*
 Interrupt priority and extended enable register block. Holds the basic
 priority register, the first extended enable and first extended priority
 registers, combines peripheral flags into masked requests and picks the
 request presented to the core.
 Assumes the core supplies the global enable, the classic enable bits and
 the level of the routine in service, all on i_clk. Peripheral flags come
 from logic on the same clock and are not synchronised.
*/
`timescale 1ns/100ps
// Notes on behaviour
// - Basic priority bit 7 reads one, ignores writes
// - Bit 6 sets serial port priority
// - Bits 5,3,1 set timer 2,1,0 priority
// - Bit 4 sets UART priority
// - Bits 2,0 set external 1,0 priority
// - Basic priority at B8, bit access, all pages
// - Extended enable bit 7 masks LIN
// - Bit 6 masks both timer 3 flags
// - Bit 5 masks both comparator 1 flags
// - Bit 4 masks both comparator 0 flags
// - Bit 3 masks all counter array requests
// - Bit 2 masks ADC conversion done
// - Bit 1 masks ADC window compare
// - Bit 0 masks SMBus requests
// - Extended enable at E6, all pages
// - Extended priority bit 7: LIN priority
// - Bit 6: timer 3 priority
// - Bits 5,4: comparator 1,0 priority
// - Bit 3: counter array priority
// - Bits 2,1: ADC done, window priority
// - Bit 0: SMBus priority
// - Extended priority at F6, pages 00/0F only
// - Global enable overrides every mask
module iper_regs (
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // Special-function bus
   input iper_pkg::iper_sfr_req_t i_sfr,
   output logic [7:0] o_rdata,
   output logic o_hit,
   // Core enable state
   input wire logic i_global_irq_enable,
   input wire logic [6:0] i_basic_enable,
   input wire logic [6:0] i_basic_pending,
   input wire logic i_in_low,
   input wire logic i_in_high,
   // Peripheral flags
   input iper_pkg::iper_ext_flags_t i_ext_flags,
   // Requests to the core
   output iper_pkg::iper_grant_t o_grant,
   output logic [iper_pkg::NUM_SOURCES-1:0] o_masked_pending,
   // Register contents
   output logic [7:0] o_basic_priority,
   output logic [7:0] o_extended_enable_one,
   output logic [7:0] o_extended_priority_one
);

   localparam int NS = iper_pkg::NUM_SOURCES;

   logic sel_basic;
   logic sel_enable;
   logic sel_prio;
   logic [7:0] basic_priority;
   logic [7:0] extended_enable_one;
   logic [7:0] extended_priority_one;
   logic [7:0] next_rdata;
   logic [7:0] rdata;
   logic [7:0] ext_req;
   logic [NS-1:0] pending;
   logic [NS-1:0] prio_high;
   iper_pkg::iper_grant_t grant;

   assign sel_basic = (i_sfr.addr == iper_pkg::ADDR_BASIC_PRIORITY);
   assign sel_enable = (i_sfr.addr == iper_pkg::ADDR_EXT_ENABLE_ONE);
   assign sel_prio = (i_sfr.addr == iper_pkg::ADDR_EXT_PRIORITY_ONE)
      && ((i_sfr.page == iper_pkg::PAGE_PRIO_A) || (i_sfr.page == iper_pkg::PAGE_PRIO_B));

   iper_sfr_reg #(
      .RESET_VALUE(iper_pkg::RST_BASIC_PRIORITY),
      .WRITE_MASK(iper_pkg::BASIC_PRIORITY_WMASK),
      .FIXED_VALUE(iper_pkg::BASIC_PRIORITY_FIXED)
   ) u_basic (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_wr(i_sfr.wr && sel_basic),
      .i_bit_op(i_sfr.bit_op),
      .i_bit_sel(i_sfr.bit_sel),
      .i_wdata(i_sfr.wdata),
      .o_value(basic_priority)
   );

   iper_sfr_reg #(
      .RESET_VALUE(iper_pkg::RST_EXT_ENABLE_ONE),
      .WRITE_MASK(8'hFF),
      .FIXED_VALUE(8'h00)
   ) u_enable (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_wr(i_sfr.wr && sel_enable && !i_sfr.bit_op),
      .i_bit_op(1'b0),
      .i_bit_sel(i_sfr.bit_sel),
      .i_wdata(i_sfr.wdata),
      .o_value(extended_enable_one)
   );

   iper_sfr_reg #(
      .RESET_VALUE(iper_pkg::RST_EXT_PRIORITY_ONE),
      .WRITE_MASK(8'hFF),
      .FIXED_VALUE(8'h00)
   ) u_prio (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_wr(i_sfr.wr && sel_prio && !i_sfr.bit_op),
      .i_bit_op(1'b0),
      .i_bit_sel(i_sfr.bit_sel),
      .i_wdata(i_sfr.wdata),
      .o_value(extended_priority_one)
   );

   // Read mux; bit access to the extended registers is not decoded
   // since only the basic priority register is bit-addressable
   always_comb begin
      next_rdata = rdata;
      if (i_sfr.rd) begin
         next_rdata = 8'h00;
         if (sel_basic) begin
            next_rdata = basic_priority;
         end else if (sel_enable) begin
            next_rdata = extended_enable_one;
         end else if (sel_prio) begin
            next_rdata = extended_priority_one;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata <= 8'h00;
      end else if (i_ce) begin
         rdata <= next_rdata;
      end
   end

   assign o_rdata = rdata;
   assign o_hit = sel_basic || sel_enable || sel_prio;

   // Extended sources ORed per enable position
   always_comb begin
      ext_req = 8'h00;
      ext_req[iper_pkg::BIT_LIN] = i_ext_flags.lin_pending_flag;
      ext_req[iper_pkg::BIT_TIMER_THREE] = i_ext_flags.timer_three_low_overflow
         || i_ext_flags.timer_three_high_overflow;
      ext_req[iper_pkg::BIT_COMPARATOR_ONE] = i_ext_flags.comparator_one_rise_flag
         || i_ext_flags.comparator_one_fall_flag;
      ext_req[iper_pkg::BIT_COMPARATOR_ZERO] = i_ext_flags.comparator_zero_rise_flag
         || i_ext_flags.comparator_zero_fall_flag;
      ext_req[iper_pkg::BIT_COUNTER_ARRAY] = i_ext_flags.counter_array_req;
      ext_req[iper_pkg::BIT_ADC_DONE] = i_ext_flags.adc_done_flag;
      ext_req[iper_pkg::BIT_ADC_WINDOW] = i_ext_flags.adc_window_flag;
      ext_req[iper_pkg::BIT_SMBUS] = i_ext_flags.smbus_req;
   end

   // Source k<7 is classic bit k; source 7+j is extended bit j.
   // Classic and extended masks, all gated by the global enable
   assign pending = i_global_irq_enable
      ? {ext_req & extended_enable_one, i_basic_pending & i_basic_enable}
      : '0;

   assign prio_high = {extended_priority_one, basic_priority[6:0]};

   iper_arbiter #(
      .N(NS)
   ) u_arb (
      .i_pending(pending),
      .i_prio_high(prio_high),
      .i_in_low(i_in_low),
      .i_in_high(i_in_high),
      .o_grant(grant)
   );

   assign o_grant = grant;
   assign o_masked_pending = pending;
   assign o_basic_priority = basic_priority;
   assign o_extended_enable_one = extended_enable_one;
   assign o_extended_priority_one = extended_priority_one;

endmodule

// [iper_sfr_reg.sv]
/*
 One byte-wide special-function register with whole-byte and single-bit
 writes. Bits outside the write mask are held at their fixed value.
 Assumes the decode and the write strobe come from the same clock.
*/
`timescale 1ns/100ps
module iper_sfr_reg #(
   parameter logic [7:0] RESET_VALUE = 8'h00,
   parameter logic [7:0] WRITE_MASK = 8'hFF,
   parameter logic [7:0] FIXED_VALUE = 8'h00
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // Write port
   input wire logic i_wr,
   input wire logic i_bit_op,
   input wire logic [2:0] i_bit_sel,
   input wire logic [7:0] i_wdata,
   // Contents
   output logic [7:0] o_value
);

   logic [7:0] value;
   logic [7:0] next_value;
   logic [7:0] merged;

   initial begin
      if ((RESET_VALUE & ~WRITE_MASK) != (FIXED_VALUE & ~WRITE_MASK)) begin
         $error("fixed bits disagree with reset value");
      end
   end

   always_comb begin
      merged = value;
      // Bit access writes only the selected bit from bit 0 of the data
      if (i_bit_op) begin
         merged[i_bit_sel] = i_wdata[0];
      end else begin
         merged = i_wdata;
      end
      next_value = value;
      if (i_wr) begin
         next_value = (merged & WRITE_MASK) | (FIXED_VALUE & ~WRITE_MASK);
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         value <= RESET_VALUE;
      end else if (i_ce) begin
         value <= next_value;
      end
   end

   assign o_value = value;

endmodule

// [tb.sv]
/*
 Self-checking bench for iper_regs with a core model.
 Assumes the package, the model and the checker are compiled first.
*/
`timescale 1ns/100ps
module tb;
   logic i_clk = 0;
   logic i_rst_n = 0;
   iper_pkg::iper_sfr_req_t sfr = '0;
   iper_pkg::iper_ext_flags_t fl = '0;
   iper_pkg::iper_grant_t gnt;
   logic g = 0, take = 0, ret = 0, ce = 1, hit, in_lo, in_hi;
   logic [6:0] ben = 0, bpd = 0;
   logic [7:0] rdata, bp, ee, ep, sb, se, sp;
   logic [14:0] mp;
   int n_mismatch = 0, check_count = 0;

   always #20 i_clk = ~i_clk;

   iper_regs u_iper_regs (.i_clk, .i_rst_n, .i_ce(ce), .i_sfr(sfr), .o_rdata(rdata),
      .o_hit(hit), .i_global_irq_enable(g), .i_basic_enable(ben), .i_basic_pending(bpd),
      .i_in_low(in_lo), .i_in_high(in_hi), .i_ext_flags(fl), .o_grant(gnt),
      .o_masked_pending(mp), .o_basic_priority(bp), .o_extended_enable_one(ee),
      .o_extended_priority_one(ep));
   iper_core_model u_iper_core_model (.i_clk, .i_rst_n, .i_grant(gnt), .i_take(take),
      .i_ret(ret), .o_in_low(in_lo), .o_in_high(in_hi));

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(string nm, logic [14:0] e, logic [14:0] s);
      check_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask

   // One strobe; read data and register outputs are settled on return
   task automatic acc(logic w, logic [7:0] a, logic [7:0] pg, logic b, logic [2:0] bs,
      logic [7:0] d);
      @(negedge i_clk);
      sfr = '{addr: a, page: pg, wr: w, rd: !w, bit_op: b, bit_sel: bs, wdata: d};
      @(negedge i_clk);
      sfr.wr = 0;
      sfr.rd = 0;
   endtask

   function automatic logic [14:0] exp_mp();
      logic [7:0] x;
      x = {fl[10], fl[9] | fl[8], fl[7] | fl[6], fl[5] | fl[4], fl[3:0]};
      return g ? {x & se, bpd & ben} : 15'h0;
   endfunction

   function automatic logic [5:0] exp_gr(logic [14:0] p, logic [14:0] h);
      for (int i = 0; i < 15; i++)
         if (p[i] && h[i] && !in_hi) return {2'b11, 4'(i)};
      for (int i = 0; i < 15; i++)
         if (p[i] && !in_lo && !in_hi) return {2'b10, 4'(i)};
      return 6'h0F;
   endfunction

   initial begin
      #400000;
      n_mismatch++;
      summarize();
   end

   initial begin
      logic [7:0] d, pg;
      logic [5:0] ge, gs;
      void'($urandom(32'h35A494BB));
      repeat (7) @(negedge i_clk);
      i_rst_n = 1;
      chk("bp", 8'h80, bp);
      chk("ee", 8'h00, ee);
      chk("ep", 8'h00, ep);
      acc(0, 8'hB8, 8'h00, 0, 0, 0);
      chk("rd bp", 8'h80, rdata);
      $display("test reset done");
      for (int i = 0; i < 12; i++) begin
         d = 8'($urandom);
         pg = 8'($urandom);
         acc(1, 8'hB8, pg, 0, 0, d);
         acc(0, 8'hB8, ~pg, 0, 0, 0);
         chk("rd bp", d | 8'h80, rdata);
         chk("hit bp", 1'b1, hit);
         acc(1, 8'hE6, pg, 0, 0, ~d);
         // Cast keeps the inversion at byte width against the wider argument
         chk("ee", 8'(~d), ee);
         acc(1, 8'hF6, i[0] ? 8'h0F : 8'h00, 0, 0, d);
         chk("ep", d, ep);
         acc(1, 8'hF6, pg | 8'h10, 0, 0, ~d);
         chk("ep hidden", d, ep);
         acc(0, 8'hF6, pg | 8'h10, 0, 0, 0);
         chk("rd hidden", 8'h00, rdata);
         chk("hit hidden", 1'b0, hit);
         acc(0, 8'hE6, pg, 0, 0, 0);
         chk("rd ee", 8'(~d), rdata);
         chk("hit ee", 1'b1, hit);
         acc(1, 8'hE6, pg, 1, 3'(i), 8'hFF);
         chk("ee bit op", 8'(~d), ee);
      end
      // Clock enable low must freeze the register
      ce = 0;
      acc(1, 8'hE6, 8'h00, 0, 0, d);
      chk("ee frozen", 8'(~d), ee);
      ce = 1;
      // Reset in mid-run returns every register to its reset value
      @(negedge i_clk);
      i_rst_n = 0;
      @(negedge i_clk);
      i_rst_n = 1;
      chk("bp rst", 8'h80, bp);
      chk("ee rst", 8'h00, ee);
      chk("ep rst", 8'h00, ep);
      chk("rd rst", 8'h00, rdata);
      $display("test bytes done");
      acc(1, 8'hB8, 8'h00, 0, 0, 8'h00);
      for (int b = 0; b < 8; b++) begin
         acc(1, 8'hB8, 8'($urandom), 1, 3'(b), 1);
         chk("bit set", 8'h80 | (8'h01 << b), bp);
         acc(1, 8'hB8, 8'($urandom), 1, 3'(b), 0);
         chk("bit clr", 8'h80, bp);
      end
      $display("test bits done");
      for (int i = 0; i < 300; i++) begin
         if (i % 16 == 0) begin
            {sb, se, sp} = 24'($urandom);
            acc(1, 8'hB8, 8'h00, 0, 0, sb);
            acc(1, 8'hE6, 8'h00, 0, 0, se);
            acc(1, 8'hF6, 8'h0F, 0, 0, sp);
         end
         @(negedge i_clk);
         g = ($urandom % 8) != 0;
         {ben, bpd} = 14'($urandom);
         fl = 11'($urandom);
         take = 1'($urandom);
         ret = ($urandom % 4) == 0;
         #1;
         chk("masked", exp_mp(), mp);
         ge = exp_gr(exp_mp(), {sp, sb[6:0]});
         gs = {gnt.valid, gnt.valid & gnt.high, gnt.source};
         chk("grant", ge, gs);
      end
      $display("test requests done");
      summarize();
   end
endmodule
